// File: rtl/adc_control_and_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"

module adc_control_and_result_regs
  import adc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        globalIrqEnable,
  input  wire logic        irqVectorAck,
  output var  logic        irqRequest,
  input  wire logic [6:0]  trigIn,
  input  wire logic [9:0]  afeResult,
  output var  logic        afePowerOn,
  output var  logic        afeConverting,
  output var  logic        afeInitCycle,
  output var  logic        afeDiff,
  output var  logic        afeGain20x,
  output var  logic        afeBipolar,
  output var  logic [2:0]  afePosIn,
  output var  logic [2:0]  afeNegIn,
  output var  logic [5:0]  afeChannel,
  output var  logic [1:0]  afeRefSel
);

  adc_core_if core ();

  conv_state_e state_r;
  logic        on_r;
  logic        startBit_r;
  logic        auto_r;
  logic        flag_r;
  logic        ie_r;
  logic [2:0]  div_r;
  logic        bipolar_r;
  logic [2:0]  csbSpare_r;
  logic        leftAdj_r;
  logic [2:0]  trigSrc_r;
  logic [1:0]  refSel_r;
  logic [5:0]  chanSel_r;
  logic        firstPending_r;
  logic        long_r;
  logic [4:0]  cycCnt_r;
  logic        prevTrig_r;
  chan_s       active_r;
  logic [31:0] prdata_r;

  logic        wrAcc;
  logic        rdAcc;
  logic        hitCsa;
  logic        hitCsb;
  logic        hitChan;
  logic        hitLow;
  logic        hitHigh;
  logic        mapped;
  logic        onNxt;
  logic        selTrig;
  logic        trigEdge;
  logic        swStart;
  logic        startConv;
  logic        complete;
  logic        restart;
  logic [4:0]  lastCyc;
  chan_s       decoded;
  logic [7:0]  csaView;
  logic [7:0]  rdByte;

  adc_prescaler u_prescaler (
    .clk   (clk),
    .rst_b (rst_b),
    .core  (core.pre)
  );

  adc_result_store u_result (
    .clk   (clk),
    .rst_b (rst_b),
    .core  (core.res)
  );

  // Bus decode
  always_comb begin
    hitCsa  = 1'b0;
    hitCsb  = 1'b0;
    hitChan = 1'b0;
    hitLow  = 1'b0;
    hitHigh = 1'b0;
    if (paddr == {`IDX_CTRL_A, 2'b00}) begin
      hitCsa = 1'b1;
    end else if (paddr == {`IDX_CTRL_B, 2'b00}) begin
      hitCsb = 1'b1;
    end else if (paddr == {`IDX_CHAN, 2'b00}) begin
      hitChan = 1'b1;
    end else if (paddr == {`IDX_RES_LOW, 2'b00}) begin
      hitLow = 1'b1;
    end else if (paddr == {`IDX_RES_HIGH, 2'b00}) begin
      hitHigh = 1'b1;
    end
  end

  assign mapped  = hitCsa | hitCsb | hitChan | hitLow | hitHigh;
  assign wrAcc   = psel && penable && pwrite && mapped;
  assign rdAcc   = psel && penable && !pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign csaView = {on_r, startBit_r, auto_r, flag_r, ie_r, div_r};

  always_comb begin
    rdByte = `RST_BYTE;
    if (hitCsa) begin
      rdByte = csaView;
    end else if (hitCsb) begin
      rdByte = {bipolar_r, csbSpare_r[2:1], leftAdj_r, csbSpare_r[0], trigSrc_r};
    end else if (hitChan) begin
      rdByte = {refSel_r, chanSel_r};
    end else if (hitLow) begin
      rdByte = core.lowByte;
    end else if (hitHigh) begin
      rdByte = core.highByte;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= `RST_WORD;
    end else if (psel && !penable) begin
      prdata_r <= {24'h00_0000, rdByte};
    end
  end
  assign prdata = prdata_r;

  // Control A plain fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_r   <= 1'b0;
      auto_r <= 1'b0;
      ie_r   <= 1'b0;
      div_r  <= 3'h0;
    end else if (wrAcc && hitCsa) begin
      on_r   <= pwdata[`CSA_ON];
      auto_r <= pwdata[`CSA_AUTO];
      ie_r   <= pwdata[`CSA_IE];
      div_r  <= pwdata[`CSA_DIV_HI:`CSA_DIV_LO];
    end
  end

  // Control B and channel register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bipolar_r  <= 1'b0;
      csbSpare_r <= 3'h0;
      leftAdj_r  <= 1'b0;
      trigSrc_r  <= `TRIG_FREE_RUN;
      refSel_r   <= 2'h0;
      chanSel_r  <= 6'h00;
    end else if (wrAcc && hitCsb) begin
      bipolar_r  <= pwdata[`CSB_BIPOLAR];
      csbSpare_r <= {pwdata[`CSB_SPARE6], pwdata[`CSB_SPARE5], pwdata[`CSB_SPARE3]};
      leftAdj_r  <= pwdata[`CSB_LEFT];
      trigSrc_r  <= pwdata[`CSB_TRIG_HI:`CSB_TRIG_LO];
    end else if (wrAcc && hitChan) begin
      refSel_r   <= pwdata[`CHAN_REF_HI:`CHAN_REF_LO];
      chanSel_r  <= pwdata[`CHAN_SEL_HI:`CHAN_SEL_LO];
    end
  end

  assign onNxt = (wrAcc && hitCsa) ? pwdata[`CSA_ON] : on_r;

  assign selTrig  = (trigSrc_r == `TRIG_FREE_RUN) ? 1'b0 : trigIn[trigSrc_r - 3'h1];
  // free running source yields no edge
  assign trigEdge = auto_r && on_r && (trigSrc_r != `TRIG_FREE_RUN) && selTrig
                    && !prevTrig_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevTrig_r <= 1'b0;
    end else begin
      prevTrig_r <= selTrig;
    end
  end

  assign swStart   = wrAcc && hitCsa && pwdata[`CSA_START] && onNxt;
  assign startConv = (state_r == CONV_IDLE) && (swStart || trigEdge);

  assign lastCyc  = long_r ? (`CONV_LONG_CYC - 5'h01) : (`CONV_SHORT_CYC - 5'h01);
  assign complete = (state_r == CONV_RUN) && on_r && core.tick && (cycCnt_r == lastCyc);
  assign restart  = complete && auto_r && (trigSrc_r == `TRIG_FREE_RUN) && onNxt;

  // first conversion after enabling is long
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstPending_r <= 1'b0;
    end else if (!on_r && onNxt) begin
      firstPending_r <= !startConv;
    end else if (!onNxt) begin
      firstPending_r <= 1'b0;
    end else if (startConv) begin
      firstPending_r <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= CONV_IDLE;
      cycCnt_r <= 5'h00;
      long_r   <= 1'b0;
    end else begin
      case (state_r)
        CONV_IDLE: begin
          if (startConv) begin
            state_r  <= CONV_RUN;
            cycCnt_r <= 5'h00;
            long_r   <= firstPending_r || (!on_r && onNxt);
          end
        end
        CONV_RUN: begin
          if (!onNxt) begin
            state_r <= CONV_IDLE;
          end else if (complete) begin
            cycCnt_r <= 5'h00;
            long_r   <= 1'b0;
            if (!restart) begin
              state_r <= CONV_IDLE;
            end
          end else if (core.tick) begin
            cycCnt_r <= cycCnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= CONV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startBit_r <= 1'b0;
    end else if (!onNxt) begin
      startBit_r <= 1'b0;
    end else if (startConv) begin
      startBit_r <= 1'b1;
    end else if (complete && !restart) begin
      startBit_r <= 1'b0;
    end
  end

  // flag sets on completion, set wins
  // cleared by vector or writing one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (complete) begin
      flag_r <= 1'b1;
    end else if (irqVectorAck || (wrAcc && hitCsa && pwdata[`CSA_FLAG])) begin
      flag_r <= 1'b0;
    end
  end

  assign irqRequest = flag_r && ie_r && globalIrqEnable;

  always_comb begin
    decoded      = '0;
    decoded.code = chanSel_r;
    if (chanSel_r[4:3] != 2'b00) begin
      decoded.diff    = 1'b1;
      decoded.gain20x = chanSel_r[0];
      if (chanSel_r[5]) begin
        {decoded.negIn, decoded.posIn} = pairOf(chanSel_r[4:1]);
      end else begin
        {decoded.posIn, decoded.negIn} = pairOf(chanSel_r[4:1]);
      end
    end else if (chanSel_r[5] && chanSel_r[2:0] >= 3'h3) begin
      decoded.diff    = 1'b1;
      decoded.gain20x = chanSel_r[0] || (chanSel_r[2:0] == 3'h3);
      if (chanSel_r[2:0] == 3'h3) begin
        decoded.posIn = 3'h0;
      end else if (chanSel_r[2:1] == 2'b10) begin
        decoded.posIn = 3'h3;
      end else begin
        decoded.posIn = 3'h7;
      end
      decoded.negIn = decoded.posIn;
    end else begin
      decoded.posIn = chanSel_r[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= '0;
    end else if (state_r == CONV_IDLE || complete) begin
      active_r <= decoded;
    end
  end

  assign core.enable     = on_r;
  assign core.divSel     = div_r;
  assign core.rawResult  = afeResult;
  assign core.loadReq    = complete;
  assign core.lowRead    = rdAcc && hitLow;
  assign core.highRead   = rdAcc && hitHigh;
  assign core.leftAdjust = leftAdj_r;
  assign core.signFill   = bipolar_r && active_r.diff;

  assign afePowerOn    = on_r;
  assign afeConverting = (state_r == CONV_RUN);
  assign afeInitCycle  = (state_r == CONV_RUN) && long_r;
  assign afeDiff       = active_r.diff;
  assign afeGain20x    = active_r.gain20x;
  assign afeBipolar    = bipolar_r;
  assign afePosIn      = active_r.posIn;
  assign afeNegIn      = active_r.negIn;
  assign afeChannel    = active_r.code;
  assign afeRefSel     = refSel_r;

endmodule : adc_control_and_result_regs
`default_nettype wire

// File: rtl/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL_B      6'h03
`define IDX_RES_LOW     6'h04
`define IDX_RES_HIGH    6'h05
`define IDX_CTRL_A      6'h06
`define IDX_CHAN        6'h07

// Control/status A fields
`define CSA_ON          7
`define CSA_START       6
`define CSA_AUTO        5
`define CSA_FLAG        4
`define CSA_IE          3
`define CSA_DIV_HI      2
`define CSA_DIV_LO      0

// Control/status B fields
`define CSB_BIPOLAR     7
`define CSB_SPARE6      6
`define CSB_SPARE5      5
`define CSB_LEFT        4
`define CSB_SPARE3      3
`define CSB_TRIG_HI     2
`define CSB_TRIG_LO     0

// Channel register fields
`define CHAN_REF_HI     7
`define CHAN_REF_LO     6
`define CHAN_SEL_HI     5
`define CHAN_SEL_LO     0

// Conversion lengths in converter clock cycles
`define CONV_LONG_CYC   5'h19
`define CONV_SHORT_CYC  5'h0D

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000
`define TRIG_FREE_RUN   3'h0

`endif

// File: rtl/adc_pkg.sv
package adc_pkg;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01
  } conv_state_e;

  typedef struct packed {
    logic       diff;
    logic       gain20x;
    logic [2:0] posIn;
    logic [2:0] negIn;
    logic [5:0] code;
  } chan_s;

  // Pair table indexed by code bits 4:1, normal polarity {pos, neg}
  function automatic logic [5:0] pairOf(input logic [3:0] idx);
    case (idx)
      4'h4:    pairOf = {3'h0, 3'h1};
      4'h5:    pairOf = {3'h0, 3'h3};
      4'h6:    pairOf = {3'h1, 3'h2};
      4'h7:    pairOf = {3'h1, 3'h3};
      4'h8:    pairOf = {3'h2, 3'h3};
      4'h9:    pairOf = {3'h3, 3'h4};
      4'hA:    pairOf = {3'h3, 3'h5};
      4'hB:    pairOf = {3'h3, 3'h6};
      4'hC:    pairOf = {3'h3, 3'h7};
      4'hD:    pairOf = {3'h4, 3'h5};
      4'hE:    pairOf = {3'h5, 3'h6};
      default: pairOf = {3'h6, 3'h7};
    endcase
  endfunction : pairOf

endpackage : adc_pkg

// File: rtl/adc_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adc_core_if;
  logic       enable;
  logic [2:0] divSel;
  logic       tick;
  logic [9:0] rawResult;
  logic       loadReq;
  logic       lowRead;
  logic       highRead;
  logic       leftAdjust;
  logic       signFill;
  logic [7:0] lowByte;
  logic [7:0] highByte;
  logic       locked;

  modport ctl (output enable, divSel, rawResult, loadReq, lowRead, highRead, leftAdjust,
               signFill, input tick, lowByte, highByte, locked);
  modport pre (input enable, divSel, output tick);
  modport res (input rawResult, loadReq, lowRead, highRead, leftAdjust, signFill,
               output lowByte, highByte, locked);
endinterface : adc_core_if
`default_nettype wire

// File: rtl/adc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
  input wire logic clk,
  input wire logic rst_b,
  adc_core_if.pre  core
);
  logic [6:0] cnt_r;
  logic [6:0] limit;

  // divide by two or power of two
  always_comb begin
    if (core.divSel < 3'h2) begin
      limit = 7'h01;
    end else begin
      limit = 7'((8'h01 << core.divSel) - 8'h01);
    end
  end

  // Runs only while on, restarts from zero at enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 7'h00;
    end else if (!core.enable || cnt_r >= limit) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  assign core.tick = core.enable && (cnt_r >= limit);
endmodule : adc_prescaler
`default_nettype wire

// File: rtl/adc_result_store.sv
`timescale 1ns/1ps
`default_nettype none
module adc_result_store (
  input wire logic clk,
  input wire logic rst_b,
  adc_core_if.res  core
);
  logic [9:0] result_r;
  logic       lock_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= 1'b0;
    end else if (core.highRead) begin
      lock_r <= 1'b0;
    end else if (core.lowRead) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= 10'h000;
    end else if (core.loadReq && !lock_r) begin
      result_r <= core.rawResult;
    end
  end

  always_comb begin
    if (core.leftAdjust) begin
      core.highByte = result_r[9:2];
      core.lowByte  = {result_r[1:0], 6'h00};
    end else begin
      core.highByte = {{6{core.signFill & result_r[9]}}, result_r[9:8]};
      core.lowByte  = result_r[7:0];
    end
  end

  assign core.locked = lock_r;
endmodule : adc_result_store
`default_nettype wire

// File: tb/adc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_afe_model (
  input  wire logic       converting,
  input  wire logic [9:0] sample,
  output logic      [9:0] afeResult
);
  // Holds the sample while converting, shows its inverse otherwise
  assign afeResult = converting ? sample : ~sample;
endmodule : adc_afe_model
`default_nettype wire

// File: tb/adc_control_and_result_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_and_result_regs_asserts (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr,
  input wire logic       globalIrqEnable,
  input wire logic       irqRequest,
  input wire logic       afePowerOn,
  input wire logic       afeConverting,
  input wire logic       afeInitCycle,
  input wire logic       afeDiff,
  input wire logic       afeGain20x,
  input wire logic [2:0] afePosIn,
  input wire logic [2:0] afeNegIn,
  input wire logic [5:0] afeChannel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic startSeen_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startSeen_r <= 1'b0;
    end else if (!afePowerOn) begin
      startSeen_r <= 1'b0;
    end else if (afeConverting) begin
      startSeen_r <= 1'b1;
    end
  end
  a_later_short: assert property ($rose(afeConverting) && startSeen_r |-> !afeInitCycle)
    else $error("later conversion not short");
  a_serr_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_irq_gate: assert property (irqRequest |-> globalIrqEnable)
    else $error("interrupt request without global enable");
  a_off_idle: assert property (!afePowerOn |-> !afeConverting)
    else $error("converting while switched off");
  a_start_on: assert property ($rose(afeConverting) |-> afePowerOn)
    else $error("conversion started while off");
  a_init_start: assert property ($rose(afeInitCycle) |-> $rose(afeConverting))
    else $error("long conversion not at a start");
  a_enable_init: assert property ($rose(afePowerOn) && afeConverting |-> afeInitCycle)
    else $error("start with enable not a long conversion");
  a_init_conv: assert property (afeInitCycle |-> afeConverting)
    else $error("long conversion flag while idle");
  a_gain_bit: assert property (afeDiff |-> afeGain20x == afeChannel[0])
    else $error("gain does not follow channel bit zero");
  a_pol_swap: assert property (afeDiff && afeChannel[5:3] != 3'h4
                               |-> afeChannel[5] == (afePosIn > afeNegIn))
    else $error("polarity does not follow channel top bit");
endmodule : adc_control_and_result_regs_asserts
bind adc_control_and_result_regs adc_control_and_result_regs_asserts adc_asserts_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pslverr(pslverr),
  .globalIrqEnable(globalIrqEnable), .irqRequest(irqRequest), .afePowerOn(afePowerOn),
  .afeConverting(afeConverting), .afeInitCycle(afeInitCycle), .afeDiff(afeDiff),
  .afeGain20x(afeGain20x), .afePosIn(afePosIn), .afeNegIn(afeNegIn),
  .afeChannel(afeChannel));
`default_nettype wire

// File: tb/tb_adc_control_and_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errTotal++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_adc_control_and_result_regs;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic globalIrqEnable = 1'b0, irqVectorAck = 1'b0, pready, pslverr, irqRequest;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv, seed = 32'h0001_37CA;
  logic [6:0] trigIn = 7'h00;
  logic [9:0] afeResult, sample = 10'h000;
  logic afePowerOn, afeConverting, afeInitCycle, afeDiff, afeGain20x, afeBipolar, serr;
  logic [2:0] afePosIn, afeNegIn;
  logic [5:0] afeChannel;
  logic [1:0] afeRefSel;
  logic [15:0] e;
  logic [5:0] regs [5] = '{`IDX_RES_LOW, `IDX_RES_HIGH, `IDX_CTRL_A, `IDX_CTRL_B, `IDX_CHAN};
  logic [12:0] chTab [8] = '{{6'h08, 7'h01}, {6'h09, 7'h41}, {6'h28, 7'h08}, {6'h23, 7'h40},
                              {6'h24, 7'h1B}, {6'h27, 7'h7F}, {6'h1F, 7'h77}, {6'h3E, 7'h3E}};
  int errTotal = 0, checks = 0, cyc = 0, held = 0, t0;
  bit lockd, lft, bip;

  adc_control_and_result_regs adc_control_and_result_regs_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck), .irqRequest(irqRequest),
    .trigIn(trigIn), .afeResult(afeResult), .afePowerOn(afePowerOn),
    .afeConverting(afeConverting), .afeInitCycle(afeInitCycle), .afeDiff(afeDiff),
    .afeGain20x(afeGain20x), .afeBipolar(afeBipolar), .afePosIn(afePosIn),
    .afeNegIn(afeNegIn), .afeChannel(afeChannel), .afeRefSel(afeRefSel));
  adc_afe_model adc_afe_model_i (.converting(afeConverting), .sample(sample),
                                 .afeResult(afeResult));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errTotal++;
      endOfTest();
    end
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic endOfTest();
    if (errTotal == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : endOfTest

  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdLow();
    apb(1'b0, `IDX_RES_LOW, 8'h00);
    lockd = 1'b1;
    e = lft ? {held[9:0], 6'h00} : {{6{bip & held[9]}}, held[9:0]};
    `CHK("low", e[7:0], rv[7:0])
  endtask : rdLow

  task automatic rdHigh();
    apb(1'b0, `IDX_RES_HIGH, 8'h00);
    lockd = 1'b0;
    e = lft ? {held[9:0], 6'h00} : {{6{bip & held[9]}}, held[9:0]};
    `CHK("high", e[15:8], rv[7:0])
  endtask : rdHigh

  task automatic waitDone();
    do apb(1'b0, `IDX_CTRL_A, 8'h00); while (rv[6] === 1'b1);
    if (!lockd) held = sample;
    `CHK("flag", 1'b1, rv[4])
  endtask : waitDone

  task automatic conv(input logic [7:0] ctl, input int n);
    int dv;
    dv = (ctl[2:0] < 3'h2) ? 2 : (1 << ctl[2:0]);
    sample <= 10'(xorshift());
    apb(1'b1, `IDX_CTRL_A, ctl);
    t0 = cyc;
    apb(1'b0, `IDX_CTRL_A, 8'h00);
    `CHK("start", 1'b1, rv[6])
    `CHK("flagclr", 1'b0, rv[4])
    waitDone();
    `CHK("len", 1'b1, (cyc - t0 >= n * dv - dv - 4) && (cyc - t0 <= n * dv + dv + 6))
  endtask : conv

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00);
      `CHK("reset", 8'h00, rv[7:0])
    end
    apb(1'b0, 6'h10, 8'h00);
    `CHK("slverr", 1'b1, serr)
    `CHK("unmapped", 32'h0000_0000, rv)
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `IDX_CHAN, {2'b00, chTab[i][12:7]});
      repeat (2) @(posedge clk);
      `CHK("chan", {1'b1, chTab[i][6:0]}, {afeDiff, afeGain20x, afePosIn, afeNegIn})
    end
    apb(1'b1, `IDX_CHAN, 8'hBE);
    apb(1'b0, `IDX_CHAN, 8'h00);
    `CHK("chanrd", 8'hBE, rv[7:0])
    `CHK("ref", 2'b10, afeRefSel)
    apb(1'b1, `IDX_CTRL_B, 8'h68);
    apb(1'b0, `IDX_CTRL_B, 8'h00);
    `CHK("csbrd", 8'h68, rv[7:0])
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, `IDX_CTRL_A, 8'h00);
      {bip, lft} = 2'(xorshift());
      apb(1'b1, `IDX_CTRL_B, {bip, 2'b00, lft, 4'h0});
      conv(8'hD0 | 8'(d), 25);
      `CHK("bip", bip, afeBipolar)
      conv(8'hD0 | 8'(d), 13);
      rdLow();
      rdHigh();
      lft = ~lft;
      apb(1'b1, `IDX_CTRL_B, {bip, 2'b00, lft, 4'h0});
      rdHigh();
    end
    conv(8'hD0, 13);
    rdLow();
    conv(8'hD0, 13);
    rdHigh();
    rdLow();
    rdHigh();
    conv(8'hD0, 13);
    rdLow();
    rdHigh();
    apb(1'b1, `IDX_CTRL_A, 8'hC7);
    apb(1'b1, `IDX_CHAN, 8'h08);
    @(posedge clk);
    `CHK("chanhold", 6'h3E, afeChannel)
    waitDone();
    `CHK("chanlate", 6'h08, afeChannel)
    apb(1'b1, `IDX_CHAN, 8'h3E);
    apb(1'b1, `IDX_CTRL_A, 8'h88);
    for (int g = 0; g < 2; g++) begin
      globalIrqEnable <= g[0];
      repeat (2) @(posedge clk);
      `CHK("irq", g[0], irqRequest)
    end
    irqVectorAck <= 1'b1;
    @(posedge clk);
    irqVectorAck <= 1'b0;
    @(posedge clk);
    `CHK("irqack", 1'b0, irqRequest)
    apb(1'b1, `IDX_CTRL_A, 8'hB0);
    {bip, lft} = 2'b00;
    for (int s = 1; s < 8; s++) begin
      apb(1'b1, `IDX_CTRL_B, 8'(s));
      sample <= 10'(xorshift());
      trigIn <= 7'(1 << (s - 1));
      @(posedge clk);
      trigIn <= 7'h00;
      apb(1'b0, `IDX_CTRL_A, 8'h00);
      `CHK("trig", 1'b1, rv[6])
      waitDone();
    end
    apb(1'b1, `IDX_CTRL_B, 8'h00);
    repeat (4) @(posedge clk);
    apb(1'b0, `IDX_CTRL_A, 8'h00);
    `CHK("nofree", 1'b0, rv[6])
    apb(1'b1, `IDX_CTRL_A, 8'hE0);
    repeat (90) @(posedge clk);
    apb(1'b0, `IDX_CTRL_A, 8'h00);
    `CHK("freerun", 1'b1, rv[6])
    apb(1'b1, `IDX_CTRL_A, 8'hA0);
    apb(1'b0, `IDX_CTRL_A, 8'h00);
    `CHK("wrzero", 1'b1, rv[6])
    apb(1'b1, `IDX_CTRL_A, 8'h00);
    apb(1'b0, `IDX_CTRL_A, 8'h00);
    `CHK("abort", 2'b00, {rv[6], afeConverting})
    endOfTest();
  end
endmodule : tb_adc_control_and_result_regs
`default_nettype wire
